/* core/tfs_device.sv */
// Operation
// - mode 0 free-running, 3 single-shot, others idle
// - free-running repeats frames back to back
// - single-shot sleeps until pin or register trigger
// - wake delay, then N frames, then sleep
// - triggers during a capture are ignored
// - wake delay is 64 times field plus 2
// - host keeps written wake delays within 0.4-26.2 ms; reset field 0 gives 2 ticks
// - long low pulse resets, short one triggers
// - trigger bit clears itself at last data ready
// - one fixed illumination current per frame
// - sub-frame lasts exactly 10000 ticks
// - first 8192 ticks integrate, rest processes
// - frame holds sub-frame field plus one
// - average field plus one sub-frames averaged
// - non power-of-two averages scale amplitude down
`default_nettype none
module tfs_device
    import tfs_pkg::*;
#(
    parameter int unsigned AMP_W = 16,
    parameter int unsigned SUB_TICKS = SUBFRAME_TICKS,
    parameter int unsigned INT_TICKS = INTEG_TICKS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // link to the host
    tfs_link_if.dev link,
    // front-end side
    input wire logic [CUR_W-1:0] illum_current_cfg,
    input wire logic [AMP_W-1:0] amp_sample,
    output logic integrate_active,
    output logic illum_on,
    output logic [CUR_W-1:0] illum_current
);
    localparam int unsigned SUM_W = AMP_W + SUB_W;

    // elaboration check: the result path is sized for 16 bits and the tick counter for 14
    if (AMP_W != 16 || INT_TICKS == 0 || INT_TICKS >= SUB_TICKS || SUB_TICKS > 16383) begin
        $error("tfs_device: unsupported parameter values");
    end

    typedef enum logic [1:0] {ST_SLEEP, ST_WAKE, ST_RUN} tfs_state_e;

    // shift that divides by the next power of two at or above n
    function automatic logic [3:0] tfs_ceil_log2(input logic [12:0] n);
        logic [3:0] k;
        k = 4'h0;
        for (int i = 0; i < 13; i++) begin
            if ((13'h0001 << i) < n) begin
                k = 4'(i + 1);
            end
        end
        return k;
    endfunction

    tfs_state_e state_r;
    logic [7:0] acc_r;
    logic tick_r;
    logic pin_s1_r, pin_s2_r, pin_prev_r;
    logic [11:0] low_cnt_r;
    logic pin_reset_r, pin_trig_r;
    logic [13:0] wake_r;
    logic [1:0] mode_r;
    logic [5:0] nfrm_r;
    logic [11:0] sub_r, avg_r;
    logic trig_bit_r;
    logic [19:0] wake_cnt_r;
    logic [13:0] sub_tick_r;
    logic [11:0] sub_idx_r, n_sub_r, n_avg_r;
    logic [6:0] frame_cnt_r;
    logic [SUM_W-1:0] amp_acc_r;
    logic [23:0] rdata_r;
    logic frame_start_r, data_ready_r;
    logic [AMP_W-1:0] amp_res_r;
    logic integ_r;
    logic [CUR_W-1:0] cur_r;

    logic [8:0] acc_sum;
    logic soft_rst, pin_rise, trig_write, start_trig;
    logic [19:0] wake_target;
    logic wake_done, sub_end, frame_end, last_frame, keep_running, start_frame, capture_done;
    logic [SUM_W-1:0] amp_sum;
    logic [SUM_W-1:0] amp_scaled;

    // fractional divider: 40 ticks per 125 system cycles gives the 25 ns tick on average
    assign acc_sum = {1'b0, acc_r} + {1'b0, TICK_NUM};
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            acc_r <= 8'h00;
            tick_r <= 1'b0;
        end else if (acc_sum >= {1'b0, TICK_DEN}) begin
            acc_r <= 8'(acc_sum - {1'b0, TICK_DEN});
            tick_r <= 1'b1;
        end else begin
            acc_r <= acc_sum[7:0];
            tick_r <= 1'b0;
        end
    end

    // pin synchroniser; only the second stage is looked at
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
            pin_prev_r <= 1'b1;
        end else begin
            pin_s1_r <= link.reset_trigger_pin_n;
            pin_s2_r <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end

    assign pin_rise = pin_s2_r && !pin_prev_r;

    // low-time counter saturates at the reset width, so a long hold cannot wrap
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt_r <= 12'h000;
        end else if (pin_s2_r) begin
            low_cnt_r <= 12'h000;
        end else if (low_cnt_r < RESET_MIN_CYC) begin
            low_cnt_r <= low_cnt_r + 12'h001;
        end
    end

    // pulse width is judged at release, so a reset takes effect when the pin goes high
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_reset_r <= 1'b0;
            pin_trig_r <= 1'b0;
        end else begin
            pin_reset_r <= pin_rise && (low_cnt_r >= RESET_MIN_CYC);
            pin_trig_r <= pin_rise && (low_cnt_r >= TRIG_MIN_CYC) && (low_cnt_r <= TRIG_MAX_CYC);
        end
    end

    assign soft_rst = pin_reset_r;
    assign trig_write = link.reg_wr && (link.reg_addr == REG_TRIG_IDX) && link.reg_wdata[TRIG_BIT];
    assign start_trig = pin_trig_r || trig_write;

    // configuration registers, cleared again by a pin reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wake_r <= WAKE_RST;
            mode_r <= MODE_RST;
            nfrm_r <= NFRM_RST;
            sub_r <= SUB_RST;
            avg_r <= AVG_RST;
        end else if (soft_rst) begin
            wake_r <= WAKE_RST;
            mode_r <= MODE_RST;
            nfrm_r <= NFRM_RST;
            sub_r <= SUB_RST;
            avg_r <= AVG_RST;
        end else if (link.reg_wr) begin
            if (link.reg_addr == REG_WAKE_IDX) begin
                wake_r <= link.reg_wdata[WAKE_LSB +: WAKE_W];
            end
            if (link.reg_addr == REG_MODE_IDX) begin
                mode_r <= link.reg_wdata[MODE_LSB +: MODE_W];
                nfrm_r <= link.reg_wdata[NFRM_LSB +: NFRM_W];
            end
            if (link.reg_addr == REG_FRAME_IDX) begin
                sub_r <= link.reg_wdata[SUB_LSB +: SUB_W];
                avg_r <= link.reg_wdata[AVG_LSB +: SUB_W];
            end
        end
    end

    // sequencer timing terms
    // ticks from trigger to frame start
    assign wake_target = (WAKE_MULT * {6'h00, wake_r}) + WAKE_ADD;
    assign wake_done = (state_r == ST_WAKE) && tick_r && (wake_cnt_r == wake_target - 20'h00001);
    assign sub_end = (state_r == ST_RUN) && tick_r && (sub_tick_r == 14'(SUB_TICKS - 1));
    assign frame_end = sub_end && (sub_idx_r == n_sub_r);
    assign last_frame = (frame_cnt_r + 7'h01) >= {1'b0, nfrm_r};
    // only code 0 repeats, only code 3 counts frames
    assign keep_running = (mode_r == MODE_CONT) || ((mode_r == MODE_MONO) && !last_frame);
    assign capture_done = frame_end && (mode_r == MODE_MONO) && last_frame;
    assign start_frame = ((state_r == ST_SLEEP) && (mode_r == MODE_CONT)) || wake_done ||
                         (frame_end && keep_running);

    // main state
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_SLEEP;
        end else if (soft_rst) begin
            state_r <= ST_SLEEP;
        end else begin
            unique case (state_r)
                ST_SLEEP: begin
                    if (start_frame) begin
                        state_r <= ST_RUN;
                    end else if ((mode_r == MODE_MONO) && start_trig) begin
                        state_r <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (wake_done) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // back to sleep after the last frame
                    if (frame_end && !keep_running) begin
                        state_r <= ST_SLEEP;
                    end
                end
            endcase
        end
    end

    // register trigger bit; a write during a capture finds the state busy and is dropped
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            trig_bit_r <= 1'b0;
        end else if (soft_rst) begin
            trig_bit_r <= 1'b0;
        end else if (capture_done) begin
            trig_bit_r <= 1'b0;
        end else if ((state_r == ST_SLEEP) && (mode_r == MODE_MONO) && trig_write) begin
            trig_bit_r <= 1'b1;
        end
    end

    // counters of wake ticks, sub-frame ticks, sub-frames and frames
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wake_cnt_r <= 20'h00000;
            sub_tick_r <= 14'h0000;
            sub_idx_r <= 12'h000;
            frame_cnt_r <= 7'h00;
        end else if (soft_rst || (state_r == ST_SLEEP)) begin
            wake_cnt_r <= 20'h00000;
            sub_tick_r <= 14'h0000;
            sub_idx_r <= 12'h000;
            frame_cnt_r <= 7'h00;
        end else begin
            if ((state_r == ST_WAKE) && tick_r) begin
                wake_cnt_r <= wake_cnt_r + 20'h00001;
            end
            if (start_frame || sub_end) begin
                sub_tick_r <= 14'h0000;
            end else if ((state_r == ST_RUN) && tick_r) begin
                sub_tick_r <= sub_tick_r + 14'h0001;
            end
            if (start_frame) begin
                sub_idx_r <= 12'h000;
            end else if (sub_end) begin
                sub_idx_r <= sub_idx_r + 12'h001;
            end
            if (frame_end) begin
                frame_cnt_r <= frame_cnt_r + 7'h01;
            end
        end
    end

    // per-frame settings are latched at frame start so host writes cannot upset a frame
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            n_sub_r <= SUB_RST;
            n_avg_r <= AVG_RST;
            cur_r <= '0;
        end else if (start_frame) begin
            n_sub_r <= sub_r;
            n_avg_r <= avg_r;
            cur_r <= illum_current_cfg;
        end
    end

    assign amp_sum = amp_acc_r + ((sub_idx_r <= n_avg_r) ? SUM_W'(amp_sample) : '0);
    // divide by next power of two
    assign amp_scaled = amp_sum >> tfs_ceil_log2({1'b0, n_avg_r} + 13'h0001);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            amp_acc_r <= '0;
            amp_res_r <= '0;
        end else if (start_frame) begin
            amp_acc_r <= '0;
            if (frame_end) begin
                amp_res_r <= amp_scaled[AMP_W-1:0];
            end
        end else if (sub_end) begin
            amp_acc_r <= amp_sum;
            if (frame_end) begin
                amp_res_r <= amp_scaled[AMP_W-1:0];
            end
        end
    end

    // event strobes and front-end levels; integration lags the tick count by one cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frame_start_r <= 1'b0;
            data_ready_r <= 1'b0;
            integ_r <= 1'b0;
        end else begin
            frame_start_r <= start_frame && !soft_rst;
            data_ready_r <= frame_end && !soft_rst;
            integ_r <= (state_r == ST_RUN) && (sub_tick_r < 14'(INT_TICKS));
        end
    end

    // register read port; unmapped indices read zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 24'h000000;
        end else if (link.reg_rd) begin
            case (link.reg_addr)
                REG_TRIG_IDX: rdata_r <= {trig_bit_r, 23'h000000};
                REG_WAKE_IDX: rdata_r <= {wake_r, 10'h000};
                REG_MODE_IDX: rdata_r <= {16'h0000, nfrm_r, mode_r};
                REG_FRAME_IDX: rdata_r <= {avg_r, sub_r};
                default: rdata_r <= 24'h000000;
            endcase
        end else begin
            rdata_r <= 24'h000000;
        end
    end

    assign link.reg_rdata = rdata_r;
    assign link.frame_start_pulse = frame_start_r;
    assign link.data_ready = data_ready_r;
    assign link.sleeping = (state_r == ST_SLEEP);
    assign link.amplitude_result = amp_res_r;
    assign integrate_active = integ_r;
    assign illum_on = integ_r;
    assign illum_current = cur_r;
endmodule
`default_nettype wire

/* core/tfs_pkg.sv */
`default_nettype none
package tfs_pkg;
    // clock rates: the sequencer counts 25 ns ticks derived from the 8 ns system clock
    localparam int unsigned T_SYS_NS = 8;
    localparam int unsigned T_TICK_NS = 25;
    localparam logic [7:0] TICK_NUM = 8'h28; // 40 ticks per 125 system cycles
    localparam logic [7:0] TICK_DEN = 8'h7d;

    // device register indices (printed offsets, not byte addresses)
    localparam logic [7:0] REG_TRIG_IDX = 8'h00;
    localparam logic [7:0] REG_WAKE_IDX = 8'h26;
    localparam logic [7:0] REG_MODE_IDX = 8'h27;
    localparam logic [7:0] REG_FRAME_IDX = 8'h9f;

    // field positions and widths
    localparam int unsigned TRIG_BIT = 23;
    localparam int unsigned WAKE_LSB = 10;
    localparam int unsigned WAKE_W = 14;
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned MODE_W = 2;
    localparam int unsigned NFRM_LSB = 2;
    localparam int unsigned NFRM_W = 6;
    localparam int unsigned SUB_LSB = 0;
    localparam int unsigned SUB_W = 12;
    localparam int unsigned AVG_LSB = 12;
    localparam int unsigned CUR_W = 5;

    // reset values of the configuration fields
    localparam logic [13:0] WAKE_RST = 14'h0000;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [5:0] NFRM_RST = 6'h00;
    localparam logic [11:0] SUB_RST = 12'h000;
    localparam logic [11:0] AVG_RST = 12'h000;

    // operating mode codes
    localparam logic [1:0] MODE_CONT = 2'h0;
    localparam logic [1:0] MODE_MONO = 2'h3;

    // sub-frame timing in ticks
    localparam int unsigned SUBFRAME_TICKS = 10000;
    localparam int unsigned INTEG_TICKS = 8192;
    localparam logic [19:0] WAKE_MULT = 20'h00040;
    localparam logic [19:0] WAKE_ADD = 20'h00002;

    // pin pulse widths
    localparam int unsigned T_TRIG_MIN_NS = 100;
    localparam int unsigned T_TRIG_MAX_NS = 1000;
    localparam int unsigned T_RESET_MIN_NS = 30000;
    localparam int unsigned T_TRIG_HOST_NS = 500;
    localparam int unsigned T_RESET_MARGIN_NS = 128;
    localparam logic [11:0] TRIG_MIN_CYC = 12'((T_TRIG_MIN_NS + T_SYS_NS - 1) / T_SYS_NS);
    localparam logic [11:0] TRIG_MAX_CYC = 12'(T_TRIG_MAX_NS / T_SYS_NS);
    localparam logic [11:0] RESET_MIN_CYC = 12'((T_RESET_MIN_NS + T_SYS_NS - 1) / T_SYS_NS);
    localparam logic [11:0] HOST_TRIG_CYC = 12'(T_TRIG_HOST_NS / T_SYS_NS);
    localparam logic [11:0] HOST_RESET_CYC =
        12'((T_RESET_MIN_NS + T_RESET_MARGIN_NS + T_SYS_NS - 1) / T_SYS_NS);

    // least wake delay; the 14-bit field itself caps the delay near 26.2 ms
    localparam int unsigned T_WAKE_MIN_NS = 400000;
    localparam logic [13:0] WAKE_MIN_FIELD =
        14'((T_WAKE_MIN_NS / T_TICK_NS - 2 + 63) / 64);

    // host controller register indices and fields
    localparam logic [2:0] H_CMD = 3'h0;
    localparam logic [2:0] H_WDATA = 3'h1;
    localparam logic [2:0] H_RDATA = 3'h2;
    localparam logic [2:0] H_STAT = 3'h3;
    localparam logic [2:0] H_MASK = 3'h4;
    localparam int unsigned CMD_RD = 8;
    localparam int unsigned CMD_TRIG = 9;
    localparam int unsigned CMD_RESET = 10;
    localparam int unsigned EV_FRAME = 0;
    localparam int unsigned EV_READY = 1;
    localparam int unsigned EV_DONE = 2;
    localparam int unsigned EV_RDONE = 3;
    localparam int unsigned EV_W = 4;
endpackage
`default_nettype wire

/* core/tfs_link_if.sv */
`default_nettype none
interface tfs_link_if;
    // register access channel
    logic [7:0] reg_addr;
    logic [23:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [23:0] reg_rdata;
    // dual-purpose reset/trigger pin, driven by the host only
    logic reset_trigger_pin_n;
    // sequencer events and results
    logic frame_start_pulse;
    logic data_ready;
    logic sleeping;
    logic [15:0] amplitude_result;

    modport dev(
        input reg_addr, reg_wdata, reg_wr, reg_rd, reset_trigger_pin_n,
        output reg_rdata, frame_start_pulse, data_ready, sleeping, amplitude_result
    );
    modport host(
        output reg_addr, reg_wdata, reg_wr, reg_rd, reset_trigger_pin_n,
        input reg_rdata, frame_start_pulse, data_ready, sleeping, amplitude_result
    );
endinterface
`default_nettype wire

/* core/tfs_host.sv */
`default_nettype none
module tfs_host
    import tfs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // link to the device
    tfs_link_if.host link,
    // software port
    input wire logic [2:0] addr,
    input wire logic [23:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [23:0] rdata,
    output logic irq
);
    logic [7:0] l_addr_r;
    logic [23:0] l_wdata_r, wbuf_r, rbuf_r, rdata_r;
    logic l_wr_r, l_rd_r, rd_pend_r, pin_n_r, sleep_d_r, irq_r;
    logic [11:0] pulse_cnt_r;
    logic [EV_W-1:0] stat_r, mask_r, ev, stat_nxt;
    logic [23:0] fwd_data;
    logic cmd_wr, pulse_idle;

    assign cmd_wr = wr && (addr == H_CMD);
    assign pulse_idle = (pulse_cnt_r == 12'h000);

    // outgoing data with the host-side limits applied
    always_comb begin
        fwd_data = wbuf_r;
        // clamp wake delay to the least
        if ((wdata[7:0] == REG_WAKE_IDX) && (wbuf_r[WAKE_LSB +: WAKE_W] < WAKE_MIN_FIELD)) begin
            fwd_data[WAKE_LSB +: WAKE_W] = WAKE_MIN_FIELD;
        end
        if ((wdata[7:0] == REG_FRAME_IDX) &&
            (wbuf_r[AVG_LSB +: SUB_W] > wbuf_r[SUB_LSB +: SUB_W])) begin
            fwd_data[AVG_LSB +: SUB_W] = wbuf_r[SUB_LSB +: SUB_W];
        end
    end

    // staged write data
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wbuf_r <= 24'h000000;
        end else if (wr && (addr == H_WDATA)) begin
            wbuf_r <= wdata;
        end
    end

    // link access: one-cycle strobes, pin pulses take priority in a command
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            l_addr_r <= 8'h00;
            l_wdata_r <= 24'h000000;
            l_wr_r <= 1'b0;
            l_rd_r <= 1'b0;
        end else begin
            l_wr_r <= 1'b0;
            l_rd_r <= 1'b0;
            if (cmd_wr && !wdata[CMD_TRIG] && !wdata[CMD_RESET]) begin
                l_addr_r <= wdata[7:0];
                l_wdata_r <= fwd_data;
                // register trigger goes out as a plain write
                l_wr_r <= !wdata[CMD_RD];
                l_rd_r <= wdata[CMD_RD];
            end
        end
    end

    // pin pulse generator; a pin command during a pulse is dropped, register commands still go out
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pulse_cnt_r <= 12'h000;
            pin_n_r <= 1'b1;
        end else if (cmd_wr && pulse_idle && wdata[CMD_RESET]) begin
            pulse_cnt_r <= HOST_RESET_CYC;
            pin_n_r <= 1'b0;
        end else if (cmd_wr && pulse_idle && wdata[CMD_TRIG]) begin
            pulse_cnt_r <= HOST_TRIG_CYC;
            pin_n_r <= 1'b0;
        end else if (!pulse_idle) begin
            pulse_cnt_r <= pulse_cnt_r - 12'h001;
            pin_n_r <= (pulse_cnt_r == 12'h001);
        end
    end

    // read return is taken the cycle after the link read
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_pend_r <= 1'b0;
            rbuf_r <= 24'h000000;
            sleep_d_r <= 1'b1; // matches sleeping in reset, so no false went-to-sleep event
        end else begin
            rd_pend_r <= l_rd_r;
            sleep_d_r <= link.sleeping;
            if (rd_pend_r) begin
                rbuf_r <= link.reg_rdata;
            end
        end
    end

    // device events; a set in the cycle of a clearing read survives
    always_comb begin
        ev = '0;
        ev[EV_FRAME] = link.frame_start_pulse;
        ev[EV_READY] = link.data_ready;
        ev[EV_DONE] = link.sleeping && !sleep_d_r;
        ev[EV_RDONE] = rd_pend_r;
        stat_nxt = ((rd && (addr == H_STAT)) ? '0 : stat_r) | ev;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stat_r <= '0;
            mask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq_r <= |(stat_nxt & mask_r);
            if (wr && (addr == H_MASK)) begin
                mask_r <= wdata[EV_W-1:0];
            end
        end
    end

    // software read port, data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 24'h000000;
        end else if (rd) begin
            case (addr)
                H_CMD: rdata_r <= {13'h0000, !pulse_idle, 2'h0, l_addr_r};
                H_WDATA: rdata_r <= wbuf_r;
                H_RDATA: rdata_r <= rbuf_r;
                H_STAT: rdata_r <= {19'h00000, link.sleeping, stat_r};
                H_MASK: rdata_r <= {20'h00000, mask_r};
                default: rdata_r <= 24'h000000;
            endcase
        end else begin
            rdata_r <= 24'h000000;
        end
    end

    assign link.reg_addr = l_addr_r;
    assign link.reg_wdata = l_wdata_r;
    assign link.reg_wr = l_wr_r;
    assign link.reg_rd = l_rd_r;
    assign link.reset_trigger_pin_n = pin_n_r;
    assign rdata = rdata_r;
    assign irq = irq_r;
endmodule
`default_nettype wire

/* sim/tfs_link_props.sv */
`default_nettype none
module tfs_link_props (
    // link signals
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic reset_trigger_pin_n,
    input wire logic frame_start_pulse,
    input wire logic data_ready,
    input wire logic sleeping,
    input wire logic [15:0] amplitude_result
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // frames and results are short pulses, far apart
    a_frame_gap: assert property (frame_start_pulse |=> !frame_start_pulse [*8]) else $error("gap");
    a_ready_pulse: assert property (data_ready |=> !data_ready [*8]) else $error("ready");
    a_ready_late: assert property (data_ready |-> !$past(frame_start_pulse)) else $error("late");
    // zero is skipped; only nrst clears the result, a pin reset leaves it unchanged
    a_amp_ready: assert property ($changed(amplitude_result) && amplitude_result != 16'h0
        |-> data_ready) else $error("amp");
    a_sleep_quiet: assert property (sleeping && $past(sleeping) |-> !data_ready) else $error("slp");
    a_start_awake: assert property (frame_start_pulse |-> !sleeping) else $error("awake");
    a_pin_width: assert property ($fell(reset_trigger_pin_n) |=> !reset_trigger_pin_n [*8])
        else $error("pin");
    a_pin_min: assert property ($rose(reset_trigger_pin_n) |-> !$past(reset_trigger_pin_n, 13))
        else $error("min");
    c_sleep: cover property ($rose(sleeping));
    c_wake: cover property ($fell(sleeping));
    c_pin: cover property ($fell(reset_trigger_pin_n));
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`default_nettype none
module tb_top import tfs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, chk_amp = 1'b0, irq;
    logic [2:0] addr = 3'h0;
    logic [23:0] wdata = 24'h0, rdata;
    logic [15:0] amp = 16'h0, exp_amp = 16'h0;
    logic [4:0] cur = 5'h0, icur;
    logic integ, ilon;
    logic [31:0] seed = 32'hd8bf;
    logic [47:0] q[$];
    logic [47:0] e;
    int n_fail = 0, cmp_count = 0, n_fs = 0;
    time t0;
    always #4 sys_clk = ~sys_clk;
    // short sub-frames keep the run brief
    tfs_link_if lk();
    tfs_device #(.SUB_TICKS(40), .INT_TICKS(32)) u_tfs_device (.sys_clk(sys_clk), .nrst(nrst),
        .link(lk.dev), .illum_current_cfg(cur), .amp_sample(amp), .integrate_active(integ),
        .illum_on(ilon), .illum_current(icur));
    tfs_host u_tfs_host (.sys_clk(sys_clk), .nrst(nrst), .link(lk.host), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    tfs_link_props u_tfs_link_props (.sys_clk(sys_clk), .nrst(nrst),
        .reset_trigger_pin_n(lk.reset_trigger_pin_n), .frame_start_pulse(lk.frame_start_pulse),
        .data_ready(lk.data_ready), .sleeping(lk.sleeping), .amplitude_result(lk.amplitude_result));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [23:0] got, input logic [23:0] x);
        cmp_count++;
        if (got !== x) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, x);
        end
    endtask
    // one strobe, dropped at the next edge
    task automatic sw(input logic [2:0] a, input logic [23:0] d, input logic w);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge sys_clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic get(input logic [2:0] a, input logic [23:0] x, input logic [23:0] m);
        q.push_back({m, x});
        sw(a, 24'h0, 1'b0);
    endtask
    // device registers go through the controller's command register
    task automatic dw(input logic [7:0] i, input logic [23:0] d);
        sw(H_WDATA, d, 1'b1);
        sw(H_CMD, {16'h0, i}, 1'b1);
    endtask
    task automatic dr(input logic [7:0] i, input logic [23:0] x, input logic [23:0] m);
        sw(H_CMD, {16'h1, i}, 1'b1);
        repeat (4) @(posedge sys_clk);
        get(H_RDATA, x, m);
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // watcher: read answers and per-frame results
    always @(posedge sys_clk) begin
        if (rd_d) begin
            e = q.pop_front();
            chk(rdata & e[47:24], e[23:0]);
        end
        if (lk.data_ready && chk_amp) begin
            chk({8'h0, lk.amplitude_result}, {8'h0, exp_amp});
            chk({19'h0, icur}, {19'h0, cur});
        end
        // blocking, so a clear from the stimulus after the edge cannot be overwritten
        if (lk.frame_start_pulse) begin
            n_fs++;
        end
        rd_d <= rd;
    end
    // the wake delay alone is about 50k cycles
    initial begin
        #(80000 * 8);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        seed = xs(seed);
        amp <= seed[15:0];
        cur <= seed[20:16];
        exp_amp = 16'((18'(seed[15:0]) * 18'h3) >> 2);
        get(H_MASK, 24'h0, 24'hf);
        dr(8'h55, 24'h0, 24'hffffff);
        // three sub-frames, all averaged: not a power of two
        dw(REG_FRAME_IDX, 24'h002002);
        dr(REG_FRAME_IDX, 24'h002002, 24'hffffff);
        @(posedge lk.frame_start_pulse);
        t0 = $time;
        @(posedge lk.frame_start_pulse);
        chk(24'((($time - t0) / 8) inside {[374:376]}), 24'h1);
        chk_amp = 1'b1;
        // integration window: 32 ticks are exactly 100 system cycles
        @(posedge integ);
        t0 = $time;
        chk({23'h0, ilon}, 24'h1);
        @(negedge integ);
        chk(24'((($time - t0) / 8) inside {[99:101]}), 24'h1);
        sw(H_MASK, 24'h2, 1'b1);
        @(posedge irq);
        get(H_STAT, 24'h2, 24'h2);
        // two-frame single shot, least wake delay after clamping
        dw(REG_WAKE_IDX, 24'h0);
        dw(REG_MODE_IDX, 24'h00000b);
        dr(REG_MODE_IDX, 24'h00000b, 24'hff);
        wait (lk.sleeping === 1'b1);
        n_fs = 0;
        dw(REG_TRIG_IDX, 24'h800000);
        t0 = $time;
        dr(REG_TRIG_IDX, 24'h800000, 24'h800000);
        @(posedge lk.frame_start_pulse);
        chk(24'((($time - t0) / 8) inside {[50000:50020]}), 24'h1);
        sw(H_CMD, 24'h200, 1'b1);
        wait (lk.sleeping === 1'b1);
        repeat (400) @(posedge sys_clk);
        chk({23'h0, lk.sleeping}, 24'h1);
        chk(24'(n_fs), 24'h2);
        dr(REG_TRIG_IDX, 24'h0, 24'h800000);
        get(H_STAT, 24'h4, 24'h4);
        repeat (3) @(posedge sys_clk);
        chk({23'h0, irq}, 24'h0);
        chk_amp = 1'b0;
        sw(H_CMD, 24'h400, 1'b1);
        repeat (3900) @(posedge sys_clk);
        dr(REG_MODE_IDX, 24'h0, 24'hff);
        @(posedge lk.frame_start_pulse);
        tally_and_finish();
    end
endmodule
`default_nettype wire
